// file: core/nand_read_host.v
// host-side read controller for an asynchronous parallel nand flash
// assumes flash pins are sampled synchronous to CLK; ready_busy_n has an external pull-up
`include "nand_host_defs.vh"

module nand_read_host
(
   // clock and reset
   input wire CLK,
   input wire RST,
   // user request
   input wire REQ_VALID,
   input wire [2:0] REQ_OP,
   input wire [39:0] REQ_ADDR,
   input wire [39:0] REQ_ADDR2,
   input wire REQ_ID_STD,
   input wire [11:0] REQ_LEN,
   output reg REQ_READY,
   // user read data
   output reg RD_VALID,
   output reg [7:0] RD_DATA,
   output reg DONE,
   output reg ERR,
   // flash pins
   output reg CE_N,
   output reg CLE,
   output reg ALE,
   output reg WE_N,
   output reg RE_N,
   output reg WP_N,
   output reg [7:0] IO_OUT,
   output reg IO_OE,
   input wire [7:0] IO_IN,
   input wire READY_BUSY_N
);

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam S_IDLE = 3'h0;
   localparam S_FETCH = 3'h1;
   localparam S_LOOK = 3'h2;
   localparam S_WR = 3'h3;
   localparam S_BUSY = 3'h4;
   localparam S_WAIT = 3'h5;
   localparam S_RD = 3'h6;

   reg [2:0] state_ff;
   reg [2:0] op_ff;
   reg [39:0] addr_ff;
   reg [39:0] addr2_ff;
   reg id_std_ff;
   reg [11:0] left_ff;
   reg [3:0] step_ff;
   reg [5:0] tmr_ff;
   reg phase_ff;
   reg two_plane_ff;
   reg status_dirty_ff;
   wire [1:0] ent_kind;
   wire [7:0] ent_byte;
   wire ent_last;
   reg [2:0] eff_op;
   reg bad_req;

   nand_seq_rom rom
   (
      .clk(CLK),
      .op(op_ff),
      .step(step_ff),
      .addr(addr_ff),
      .addr2(addr2_ff),
      .id_std(id_std_ff),
      .kind_ff(ent_kind),
      .byte_ff(ent_byte),
      .last_ff(ent_last)
   );

   // ------------------------------------------------------------
   // request screening
   // ------------------------------------------------------------
   always @*
   begin
      eff_op = REQ_OP;
      bad_req = 1'b0;
      // page read after a status poll needs the 00h again
      if (REQ_OP == `OP_INIT_READ && status_dirty_ff)
      begin
         eff_op = `OP_PAGE_READ;
      end
      // plane addresses must match except the plane bit
      if (REQ_OP == `OP_TWO_PLANE && ((REQ_ADDR ^ REQ_ADDR2) != (40'h1 << (16 + `PLANE_BIT))))
      begin
         bad_req = 1'b1;
      end
      // column bytes have zero upper nibble on cycle 2, row byte 5 top bits zero
      if (REQ_ADDR[15:12] != 4'h0 || REQ_ADDR[39:34] != 6'h00)
      begin
         bad_req = 1'b1;
      end
      // reading data after two-plane load needs a plane select first
      if (two_plane_ff && REQ_OP == `OP_RANDOM_OUT)
      begin
         bad_req = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   always @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         state_ff <= S_IDLE;
         op_ff <= 3'h0;
         addr_ff <= 40'h0000_0000_00;
         addr2_ff <= 40'h0000_0000_00;
         id_std_ff <= 1'b0;
         left_ff <= 12'h000;
         step_ff <= 4'h0;
         tmr_ff <= 6'h00;
         phase_ff <= 1'b0;
         two_plane_ff <= 1'b0;
         status_dirty_ff <= 1'b0;
         REQ_READY <= 1'b0;
         RD_VALID <= 1'b0;
         RD_DATA <= 8'h00;
         DONE <= 1'b0;
         ERR <= 1'b0;
         CE_N <= 1'b1;
         CLE <= 1'b0;
         ALE <= 1'b0;
         WE_N <= 1'b1;
         RE_N <= 1'b1;
         WP_N <= 1'b0;
         IO_OUT <= 8'h00;
         IO_OE <= 1'b0;
      end
      else
      begin
         RD_VALID <= 1'b0;
         DONE <= 1'b0;
         ERR <= 1'b0;
         case (state_ff)
            S_IDLE:
            begin
               CE_N <= 1'b1;
               IO_OE <= 1'b0;
               REQ_READY <= 1'b1;
               if (REQ_VALID && REQ_READY)
               begin
                  REQ_READY <= 1'b0;
                  if (bad_req)
                  begin
                     ERR <= 1'b1;
                     DONE <= 1'b1;
                  end
                  else
                  begin
                     op_ff <= eff_op;
                     addr_ff <= REQ_ADDR;
                     addr2_ff <= REQ_ADDR2;
                     id_std_ff <= REQ_ID_STD;
                     left_ff <= REQ_LEN;
                     step_ff <= (eff_op == `OP_INIT_READ) ? 4'h1 : 4'h0;
                     CE_N <= 1'b0;
                     state_ff <= S_FETCH;
                  end
               end
            end
            S_FETCH:
            begin
               state_ff <= S_LOOK;
            end
            S_LOOK:
            begin
               // one cycle kind per table entry; only defined codes in table
               CLE <= (ent_kind == 2'h0);
               ALE <= (ent_kind == 2'h1);
               IO_OUT <= ent_byte;
               IO_OE <= 1'b1;
               WE_N <= 1'b0;
               tmr_ff <= 6'h00;
               phase_ff <= 1'b0;
               state_ff <= S_WR;
            end
            S_WR:
            begin
               tmr_ff <= tmr_ff + 6'h01;
               if (tmr_ff == `STROBE_CYC - 1)
               begin
                  tmr_ff <= 6'h00;
                  if (!phase_ff)
                  begin
                     WE_N <= 1'b1;
                     phase_ff <= 1'b1;
                  end
                  else
                  begin
                     CLE <= 1'b0;
                     ALE <= 1'b0;
                     IO_OE <= 1'b0;
                     if (!ent_last)
                     begin
                        step_ff <= step_ff + 4'h1;
                        state_ff <= S_FETCH;
                     end
                     else
                     begin
                        case (op_ff)
                           `OP_PAGE_READ, `OP_INIT_READ:
                           begin
                              two_plane_ff <= 1'b0;
                              status_dirty_ff <= 1'b0;
                              state_ff <= S_BUSY;
                           end
                           `OP_TWO_PLANE:
                           begin
                              two_plane_ff <= 1'b1;
                              status_dirty_ff <= 1'b0;
                              state_ff <= S_BUSY;
                           end
                           `OP_STATUS:
                           begin
                              status_dirty_ff <= 1'b1;
                              left_ff <= 12'h001;
                              state_ff <= S_WAIT;
                           end
                           `OP_RESET:
                           begin
                              two_plane_ff <= 1'b0;
                              state_ff <= S_BUSY;
                           end
                           `OP_READ_ID:
                           begin
                              left_ff <= id_std_ff ? {8'h00, `ID_LEN_STD} : {8'h00, `ID_LEN_DEV};
                              state_ff <= S_WAIT;
                           end
                           default:
                           begin
                              // random out and plane select go straight to data
                              state_ff <= S_WAIT;
                              // once a plane is selected, 05h may move the column
                              two_plane_ff <= 1'b0;
                           end
                        endcase
                     end
                  end
               end
            end
            S_BUSY:
            begin
               // device pulls ready_busy_n low after the confirm; give it time to fall
               tmr_ff <= tmr_ff + 6'h01;
               if (tmr_ff >= `WB_CYC && READY_BUSY_N)
               begin
                  tmr_ff <= 6'h00;
                  // two-plane data waits for a plane select request
                  if (two_plane_ff || op_ff == `OP_RESET || left_ff == 12'h000)
                  begin
                     DONE <= 1'b1;
                     state_ff <= S_IDLE;
                  end
                  else
                  begin
                     state_ff <= S_WAIT;
                  end
               end
            end
            S_WAIT:
            begin
               tmr_ff <= tmr_ff + 6'h01;
               if (tmr_ff >= `WHR_CYC - 1)
               begin
                  tmr_ff <= 6'h00;
                  phase_ff <= 1'b0;
                  if (left_ff == 12'h000)
                  begin
                     DONE <= 1'b1;
                     state_ff <= S_IDLE;
                  end
                  else
                  begin
                     RE_N <= 1'b0;
                     state_ff <= S_RD;
                  end
               end
            end
            S_RD:
            begin
               tmr_ff <= tmr_ff + 6'h01;
               if (tmr_ff == `STROBE_CYC - 1)
               begin
                  tmr_ff <= 6'h00;
                  if (!phase_ff)
                  begin
                     RD_DATA <= IO_IN;
                     RD_VALID <= 1'b1;
                     if (op_ff == `OP_STATUS && IO_IN[`STATUS_RDY_BIT])
                     begin
                        status_dirty_ff <= 1'b1;
                     end
                     RE_N <= 1'b1;
                     phase_ff <= 1'b1;
                     left_ff <= left_ff - 12'h001;
                  end
                  else
                  begin
                     phase_ff <= 1'b0;
                     if (left_ff == 12'h000)
                     begin
                        DONE <= 1'b1;
                        state_ff <= S_IDLE;
                     end
                     else
                     begin
                        RE_N <= 1'b0;
                     end
                  end
               end
            end
            default:
            begin
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

endmodule // nand_read_host

// file: core/nand_host_defs.vh
// command codes, cycle counts and pin timing for the nand read host
// assumes a 250 MHz system clock and an 8-bit flash bus
`ifndef NAND_HOST_DEFS_VH
`define NAND_HOST_DEFS_VH

// ------------------------------------------------------------
// command codes
// ------------------------------------------------------------
`define CMD_READ1        8'h00
`define CMD_READ2        8'h30
`define CMD_RND_OUT1     8'h05
`define CMD_RND_OUT2     8'hE0
`define CMD_PLANE_SEL    8'h06
`define CMD_STATUS       8'h70
`define CMD_STATUS_ENH   8'h78
`define CMD_READ_ID      8'h90
`define CMD_RESET        8'hFF
`define ID_ADDR_DEV      8'h00
`define ID_ADDR_STD      8'h20

// ------------------------------------------------------------
// operation codes on the user port
// ------------------------------------------------------------
`define OP_PAGE_READ     3'h0
`define OP_TWO_PLANE     3'h1
`define OP_RANDOM_OUT    3'h2
`define OP_PLANE_SEL     3'h3
`define OP_READ_ID       3'h4
`define OP_STATUS        3'h5
`define OP_RESET         3'h6
`define OP_INIT_READ     3'h7

// ------------------------------------------------------------
// field positions and counts
// ------------------------------------------------------------
`define PLANE_BIT        6
`define STATUS_RDY_BIT   6
`define ID_LEN_DEV       4'h5
`define ID_LEN_STD       4'h4

// ------------------------------------------------------------
// timing: ns figures and cycle counts at 4 ns
// ------------------------------------------------------------
`define CLK_PERIOD_NS    4
`define STROBE_NS        20
`define STROBE_CYC       ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WHR_NS           80
`define WHR_CYC          ((`WHR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WB_NS            100
`define WB_CYC           ((`WB_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: core/nand_seq_rom.v
// byte sequencer table: maps operation and step to one bus cycle
// assumes the caller steps through entries until the last flag
`include "nand_host_defs.vh"

module nand_seq_rom
(
   // clock
   input wire clk,
   // lookup
   input wire [2:0] op,
   input wire [3:0] step,
   input wire [39:0] addr,
   input wire [39:0] addr2,
   input wire id_std,
   // entry: kind 0 cmd, 1 addr; data; last
   output reg [1:0] kind_ff,
   output reg [7:0] byte_ff,
   output reg last_ff
);

   reg [1:0] nxt_kind;
   reg [7:0] nxt_byte;
   reg nxt_last;

   always @*
   begin
      nxt_kind = 2'h0;
      nxt_byte = 8'h00;
      nxt_last = 1'b0;
      case (op)
         `OP_PAGE_READ, `OP_INIT_READ:
         begin
            // init read skips the leading 00h, already latched at power-on
            if (step == 4'h0)
            begin
               nxt_byte = `CMD_READ1;
            end
            else if (step <= 4'h5)
            begin
               nxt_kind = 2'h1;
               nxt_byte = addr[8*(step-4'h1) +: 8];
            end
            else
            begin
               nxt_byte = `CMD_READ2;
               nxt_last = 1'b1;
            end
         end
         `OP_TWO_PLANE:
         begin
            if (step == 4'h0 || step == 4'h6)
            begin
               nxt_byte = `CMD_READ1;
            end
            else if (step <= 4'h5)
            begin
               nxt_kind = 2'h1;
               nxt_byte = addr[8*(step-4'h1) +: 8];
            end
            else if (step <= 4'hB)
            begin
               nxt_kind = 2'h1;
               nxt_byte = addr2[8*(step-4'h7) +: 8];
            end
            else
            begin
               nxt_byte = `CMD_READ2;
               nxt_last = 1'b1;
            end
         end
         `OP_RANDOM_OUT:
         begin
            if (step == 4'h0)
            begin
               nxt_byte = `CMD_RND_OUT1;
            end
            else if (step <= 4'h2)
            begin
               nxt_kind = 2'h1;
               nxt_byte = addr[8*(step-4'h1) +: 8];
            end
            else
            begin
               nxt_byte = `CMD_RND_OUT2;
               nxt_last = 1'b1;
            end
         end
         `OP_PLANE_SEL:
         begin
            if (step == 4'h0)
            begin
               nxt_byte = `CMD_PLANE_SEL;
            end
            else if (step <= 4'h5)
            begin
               nxt_kind = 2'h1;
               nxt_byte = addr[8*(step-4'h1) +: 8];
            end
            else
            begin
               nxt_byte = `CMD_RND_OUT2;
               nxt_last = 1'b1;
            end
         end
         `OP_READ_ID:
         begin
            if (step == 4'h0)
            begin
               nxt_byte = `CMD_READ_ID;
            end
            else
            begin
               nxt_kind = 2'h1;
               nxt_byte = id_std ? `ID_ADDR_STD : `ID_ADDR_DEV;
               nxt_last = 1'b1;
            end
         end
         `OP_STATUS:
         begin
            nxt_byte = `CMD_STATUS;
            nxt_last = 1'b1;
         end
         default:
         begin
            nxt_byte = `CMD_RESET;
            nxt_last = 1'b1;
         end
      endcase
   end

   always @(posedge clk)
   begin
      kind_ff <= nxt_kind;
      byte_ff <= nxt_byte;
      last_ff <= nxt_last;
   end

endmodule // nand_seq_rom

// file: tb/nand_read_host_assertions.sv
// pin and handshake checks for the nand read host
// assumes binding to nand_read_host; sees its ports only
module nand_read_host_assertions
(
   // clock and reset
   input wire CLK,
   input wire RST,
   // user side
   input wire REQ_VALID,
   input wire REQ_READY,
   input wire DONE,
   input wire ERR,
   // flash pins
   input wire CE_N,
   input wire CLE,
   input wire ALE,
   input wire WE_N,
   input wire RE_N,
   input wire WP_N,
   input wire IO_OE,
   input wire READY_BUSY_N
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   // ---------------
   // strobe shapes
   // ---------------
   sequence we_strobe;
      !WE_N [*5] ##1 WE_N;
   endsequence
   sequence re_strobe;
      !RE_N [*5] ##1 RE_N;
   endsequence
   AST_CMD_FRAME: assert property (CLE |-> !ALE && !CE_N && RE_N)
      else $error("command cycle framed wrongly");
   AST_ADDR_FRAME: assert property (ALE |-> !CLE && !CE_N && RE_N)
      else $error("address cycle framed wrongly");
   AST_WE_LATCH: assert property ($rose(WE_N) |-> (CLE ^ ALE) && IO_OE)
      else $error("write strobe rose without a latch enable");
   AST_WE_WIDTH: assert property ($fell(WE_N) |-> we_strobe)
      else $error("write strobe width wrong");
   AST_RE_WIDTH: assert property ($fell(RE_N) |-> re_strobe)
      else $error("read strobe width wrong");
   AST_RE_IDLE: assert property (!RE_N |-> !IO_OE && !CLE && !ALE && !CE_N)
      else $error("read strobe while bus driven");
   AST_NO_RE_BUSY: assert property (!READY_BUSY_N |-> RE_N)
      else $error("read strobe while busy");
   AST_WP_LOW: assert property (WP_N == 1'b0)
      else $error("write protect released");
   AST_DONE_READY: assert property (DONE |-> READY_BUSY_N)
      else $error("done while device busy");
   AST_ERR_DONE: assert property (ERR |-> DONE)
      else $error("error without done");
   AST_TAKE_DROP: assert property (REQ_VALID && REQ_READY |=> !REQ_READY)
      else $error("ready held after take");
endmodule // nand_read_host_assertions

bind nand_read_host nand_read_host_assertions chk
(
   .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_READY(REQ_READY), .DONE(DONE),
   .ERR(ERR), .CE_N(CE_N), .CLE(CLE), .ALE(ALE), .WE_N(WE_N), .RE_N(RE_N), .WP_N(WP_N),
   .IO_OE(IO_OE), .READY_BUSY_N(READY_BUSY_N)
);

// file: tb/nand_flash_model.sv
// behavioural nand device answering the read host
// assumes pins sampled on clk; the bench resolves bus and pull-up
module nand_flash_model
#(
   parameter logic [7:0] ID_DEV_BASE = 8'hA0, // arbitrary
   parameter logic [7:0] ID_STD_BASE = 8'hC0, // arbitrary
   parameter int WHR = 16
)
(
   // clock and reset
   input wire clk,
   input wire rst,
   // host pins
   input wire ce_n,
   input wire cle,
   input wire ale,
   input wire we_n,
   input wire re_n,
   input wire [7:0] bus_in,
   // array read time in cycles
   input wire [15:0] tr_cyc,
   // device side
   output logic [7:0] dq,
   output logic busy,
   output int viol
);
   timeunit 1ns;
   timeprecision 1ps;
   logic we_q, re_q, stat, idm, ids, two, pend2, sel06, pl;
   logic [7:0] cmd, cur;
   logic [7:0] row3 [2];
   logic [7:0] nrow [2];
   logic [39:0] ad;
   logic [2:0] na;
   logic [11:0] col;
   int bcnt, wcnt;
   function automatic logic known(input logic [7:0] x);
      return x inside {8'h00, 8'h30, 8'h35, 8'h90, 8'h70, 8'h78, 8'hFF, 8'h80, 8'h85, 8'h10,
         8'h11, 8'h81, 8'h60, 8'hD0, 8'hD1, 8'h05, 8'hE0, 8'h06} || x[7:2] == 6'h3B;
   endfunction
   always_comb
   begin
      if (stat)
         cur = busy ? 8'h00 : 8'h40;
      else if (idm)
         cur = (ids ? ID_STD_BASE : ID_DEV_BASE) + col[7:0];
      else
         cur = row3[pl] + col[7:0];
   end
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         {we_q, re_q, stat, idm, ids, two, pend2, sel06, pl, busy} <= 10'h300;
         cmd <= 8'h00;
         na <= 3'h0;
         col <= 12'h000;
         ad <= 40'h00_0000_0000;
         dq <= 8'h00;
         bcnt <= 0;
         wcnt <= 0;
         viol <= 0;
      end
      else
      begin
         we_q <= we_n;
         re_q <= re_n;
         // released bus inverts every cycle, so the last byte shows again every other cycle
         dq <= re_n ? ~dq : cur;
         wcnt <= wcnt + 1;
         if (bcnt != 0)
            bcnt <= bcnt - 1;
         busy <= (bcnt > 1);
         if (!ce_n && re_q && !re_n && (busy || (sel06 && wcnt < WHR)))
            viol <= viol + 1;
         if (!ce_n && !re_q && re_n)
            col <= col + 12'h001;
         if (!ce_n && !we_q && we_n && ale)
         begin
            ad[na*8 +: 8] <= bus_in;
            na <= na + 3'h1;
            if (na == 3'h2 && cmd == 8'h00)
               nrow[bus_in[6]] <= bus_in;
            if (cmd == 8'h90)
            begin
               idm <= 1'b1;
               ids <= (bus_in == 8'h20);
               col <= 12'h000;
            end
         end
         if (!ce_n && !we_q && we_n && cle)
         begin
            cmd <= bus_in;
            na <= 3'h0;
            wcnt <= 0;
            sel06 <= 1'b0;
            stat <= 1'b0;
            idm <= 1'b0;
            if (!known(bus_in))
               viol <= viol + 1;
            case (bus_in)
               8'h00: pend2 <= (na == 3'h5 && cmd == 8'h00);
               8'h30:
               begin
                  // a 30h not preceded by 00h is a host slip
                  if (cmd != 8'h00)
                     viol <= viol + 1;
                  busy <= 1'b1;
                  bcnt <= tr_cyc;
                  row3 <= nrow;
                  col <= ad[11:0];
                  pl <= ad[22];
                  two <= pend2;
               end
               8'hE0:
               begin
                  col <= ad[11:0];
                  if (cmd == 8'h06)
                  begin
                     pl <= ad[22];
                     sel06 <= 1'b1;
                     if (busy)
                        viol <= viol + 1;
                  end
               end
               8'h70: stat <= 1'b1;
               8'h78:
               begin
                  stat <= 1'b1;
                  if (two)
                     viol <= viol + 1;
               end
               8'hFF:
               begin
                  busy <= 1'b1;
                  bcnt <= 8;
                  two <= 1'b0;
               end
               default: ;
            endcase
         end
      end
   end
endmodule // nand_flash_model

// file: tb/test_nand_read_host.sv
// self-checking bench: nand read host against the device model
// assumes the host, its defines header and the model are compiled first
`include "nand_host_defs.vh"
module test_nand_read_host;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] ID_DEV_BASE = 8'hA0; // arbitrary
   localparam logic [7:0] ID_STD_BASE = 8'hC0; // arbitrary
   logic CLK, RST, REQ_VALID, REQ_ID_STD, err_seen;
   logic [2:0] REQ_OP;
   logic [39:0] REQ_ADDR, REQ_ADDR2, a, b, c;
   logic [11:0] REQ_LEN;
   logic [15:0] tr;
   logic [31:0] seed;
   logic [7:0] got [$];
   wire REQ_READY, RD_VALID, DONE, ERR, CE_N, CLE, ALE, WE_N, RE_N, WP_N, IO_OE, busy;
   wire [7:0] RD_DATA, IO_OUT, io_bus, dq;
   wire READY_BUSY_N;
   int viol, miscompares, comparisons, k, n;
   assign io_bus = IO_OE ? IO_OUT : dq;
   // open drain with pull-up
   assign READY_BUSY_N = busy ? 1'b0 : 1'b1;
   nand_read_host dut
   (
      .CLK(CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_OP(REQ_OP), .REQ_ADDR(REQ_ADDR),
      .REQ_ADDR2(REQ_ADDR2), .REQ_ID_STD(REQ_ID_STD), .REQ_LEN(REQ_LEN), .REQ_READY(REQ_READY),
      .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .DONE(DONE), .ERR(ERR), .CE_N(CE_N), .CLE(CLE),
      .ALE(ALE), .WE_N(WE_N), .RE_N(RE_N), .WP_N(WP_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
      .IO_IN(io_bus), .READY_BUSY_N(READY_BUSY_N)
   );
   nand_flash_model #(.ID_DEV_BASE(ID_DEV_BASE), .ID_STD_BASE(ID_STD_BASE),
      .WHR(`WHR_CYC)) dev
   (
      .clk(CLK), .rst(RST), .ce_n(CE_N), .cle(CLE), .ale(ALE), .we_n(WE_N), .re_n(RE_N),
      .bus_in(io_bus), .tr_cyc(tr), .dq(dq), .busy(busy), .viol(viol)
   );
   initial
   begin
      CLK = 1'b0;
      forever #2 CLK = ~CLK;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   // reserved high bits of cycles two and five stay low
   function automatic logic [39:0] rnd_addr();
      seed = lfsr(seed);
      return {6'h00, seed[17:16], seed[15:8], seed[31:24], 5'h00, seed[20:18], seed[7:0]};
   endfunction
   function automatic logic [7:0] pbyte(input logic [39:0] x, input int i);
      return x[23:16] + x[7:0] + i[7:0];
   endfunction
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_bit(input string nm, input logic e, input logic g);
      comparisons++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic chk_page(input logic [39:0] x, input int cnt);
      chk_byte("count", cnt[7:0], 8'(got.size()));
      for (int i = 0; i < cnt; i++)
         chk_byte("data", pbyte(x, i), got[i]);
   endtask
   task automatic run_op(input logic [2:0] op, input logic [39:0] x, input logic [39:0] y,
                         input logic sd, input logic [11:0] len);
      got.delete();
      REQ_OP <= op;
      REQ_ADDR <= x;
      REQ_ADDR2 <= y;
      REQ_ID_STD <= sd;
      REQ_LEN <= len;
      REQ_VALID <= 1'b1;
      @(posedge CLK);
      while (REQ_READY !== 1'b1)
         @(posedge CLK);
      REQ_VALID <= 1'b0;
      for (k = 0; k < 20000; k++)
      begin
         @(posedge CLK);
         if (RD_VALID === 1'b1)
            got.push_back(RD_DATA);
         if (DONE === 1'b1)
            break;
      end
      // an operation that never ends counts against the run
      if (k == 20000)
         miscompares++;
      err_seen = ERR;
   endtask
   task automatic wrap_up();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   initial
   begin
      repeat (60000) @(posedge CLK);
      miscompares++;
      wrap_up();
   end
   initial
   begin
      {RST, REQ_VALID, REQ_ID_STD, REQ_OP} = 6'h20;
      {REQ_ADDR, REQ_ADDR2, REQ_LEN} = 92'h000_0000_0000_0000_0000_0000;
      {miscompares, comparisons} = 64'h0000_0000_0000_0000;
      seed = 32'h0000_21ca;
      tr = 16'h0040;
      repeat (20) @(posedge CLK);
      RST <= 1'b0;
      repeat (2) @(posedge CLK);
      a = rnd_addr();
      run_op(`OP_INIT_READ, a, a, 1'b0, 12'h004);
      chk_page(a, 4);
      repeat (4)
      begin
         a = rnd_addr();
         n = 1 + seed[3:0];
         // busy time from prompt to slow
         tr <= 16'h0010 + seed[13:6];
         run_op(`OP_PAGE_READ, a, a, 1'b0, n[11:0]);
         chk_page(a, n);
      end
      b = rnd_addr();
      run_op(`OP_RANDOM_OUT, b, b, 1'b0, 12'h003);
      chk_page({a[39:16], b[15:0]}, 3);
      run_op(`OP_STATUS, a, a, 1'b0, 12'h001);
      chk_byte("status", 8'h40, got[0]);
      run_op(`OP_INIT_READ, a, a, 1'b0, 12'h002);
      chk_page(a, 2);
      $display("test page reads ended");
      a = rnd_addr();
      a[22] = 1'b0;
      b = a;
      b[22] = 1'b1;
      run_op(`OP_TWO_PLANE, a, b, 1'b0, 12'h000);
      chk_bit("err", 1'b0, err_seen);
      run_op(`OP_RANDOM_OUT, a, a, 1'b0, 12'h002);
      chk_bit("err", 1'b1, err_seen);
      for (int p = 0; p < 2; p++)
      begin
         c = rnd_addr();
         c[39:16] = p ? b[39:16] : a[39:16];
         run_op(`OP_PLANE_SEL, c, c, 1'b0, 12'h006);
         chk_page(c, 6);
      end
      a = rnd_addr();
      run_op(`OP_RANDOM_OUT, a, a, 1'b0, 12'h004);
      chk_page({c[39:16], a[15:0]}, 4);
      b = c ^ 40'h00_00C0_0000;
      run_op(`OP_TWO_PLANE, c, b, 1'b0, 12'h000);
      chk_bit("err", 1'b1, err_seen);
      run_op(`OP_PAGE_READ, c | 40'h00_0000_2000, c, 1'b0, 12'h001);
      chk_bit("err", 1'b1, err_seen);
      $display("test two-plane ended");
      for (int s = 0; s < 2; s++)
      begin
         run_op(`OP_READ_ID, a, a, s[0], 12'h000);
         chk_byte("id count", s ? 8'h04 : 8'h05, 8'(got.size()));
         foreach (got[i])
            chk_byte("id", (s ? ID_STD_BASE : ID_DEV_BASE) + i[7:0], got[i]);
      end
      run_op(`OP_RESET, a, a, 1'b0, 12'h000);
      chk_bit("err", 1'b0, err_seen);
      a = rnd_addr();
      run_op(`OP_PAGE_READ, a, a, 1'b0, 12'h008);
      chk_page(a, 8);
      chk_bit("device protocol", 1'b1, viol == 0);
      $display("test id and reset ended");
      wrap_up();
   end
endmodule // test_nand_read_host
